// *** bridge_address_remapper.sv ***
// bridge address remapper: downstream i/o aliasing, downstream memory window shift,
// secondary-side claim exclusion and upstream dma window relocation
// assumes requests come from logic on i_ref_clk; answers are registered one cycle later
//
// Notes on behaviour
// - downstream i/o: drop the number of upper address bits given by i/o size
// - claim downstream memory exactly inside memory base/limit, regardless of remap
// - non-prefetchable secondary address = primary minus base difference
// - prefetchable secondary address = primary minus base difference
// - never claim secondary cycles inside either shifted secondary window, unless a dma window hits there
// - non-prefetchable secondary limit = primary limit minus base difference
// - prefetchable secondary limit = primary limit minus base difference
// - each dma window primary limit = secondary limit plus its base difference
// - upstream hit in a dma window adds that window's base difference
// - upstream misses everywhere pass up with address unchanged
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module bridge_address_remapper #(
    parameter int PRI_AW    = remap_pkg::PRI_AW,
    parameter int SEC_AW    = remap_pkg::SEC_AW,
    parameter int IO_AW     = remap_pkg::IO_AW,
    parameter int WIN_COUNT = remap_pkg::WIN_COUNT
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset,
    // register port
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic [31:0]           i_reg_wdata,
    input  wire logic                  i_reg_write,
    input  wire logic                  i_reg_read,
    output logic [31:0]                o_reg_rdata,
    // downstream request from primary link, answer toward secondary bus
    input  wire remap_pkg::down_req_t  i_down,
    output remap_pkg::down_rsp_t       o_down,
    // upstream request from secondary bus, answer toward primary link
    input  wire remap_pkg::up_req_t    i_up,
    output remap_pkg::up_rsp_t         o_up,
    // decode state for the bridge header
    output logic                       o_decode_undefined
);

////////////////////////////////////////////////////////////////////////////////

    logic [2:0]  ctrl_reg;
    logic [4:0]  io_size_reg;
    logic [31:0] np_pri_base_reg;
    logic [31:0] np_pri_lim_reg;
    logic [31:0] np_sec_base_reg;
    logic [31:0] pf_pri_base_reg;
    logic [31:0] pf_pri_lim_reg;
    logic [31:0] pf_sec_base_reg;

    // one entry per window
    logic [31:0] win_sec_base_reg [WIN_COUNT];
    logic [31:0] win_sec_lim_reg  [WIN_COUNT];
    logic [31:0] win_pri_base_reg [WIN_COUNT];

    // granule register to byte address; limits fill the low bits with ones
    function automatic logic [PRI_AW-1:0] to_base(input logic [31:0] g);
        to_base = {g, {remap_pkg::GRAN_SHIFT{1'b0}}};
    endfunction

    function automatic logic [PRI_AW-1:0] to_limit(input logic [31:0] g);
        to_limit = {g, {remap_pkg::GRAN_SHIFT{1'b1}}};
    endfunction

    function automatic logic [31:0] to_gran(input logic [PRI_AW-1:0] a);
        to_gran = a[PRI_AW-1:remap_pkg::GRAN_SHIFT];
    endfunction

    // inclusive both ends
    function automatic logic in_range(input logic [PRI_AW-1:0] a,
                                      input logic [PRI_AW-1:0] lo,
                                      input logic [PRI_AW-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // stride-spaced window map
    function automatic logic win_sel(input logic [7:0] a, input int w, input logic [7:0] f);
        win_sel = (a == 8'(remap_pkg::OFS_WIN0 + 8'(w) * remap_pkg::WIN_STRIDE + f));
    endfunction

////////////////////////////////////////////////////////////////////////////////
// derived window values

    logic [PRI_AW-1:0] nonpref_primary_base;
    logic [PRI_AW-1:0] nonpref_primary_limit;
    logic [PRI_AW-1:0] nonpref_secondary_base;
    logic [PRI_AW-1:0] nonpref_secondary_limit;
    logic [PRI_AW-1:0] nonpref_base_offset;
    logic [PRI_AW-1:0] pref_primary_base;
    logic [PRI_AW-1:0] pref_primary_limit;
    logic [PRI_AW-1:0] pref_secondary_base;
    logic [PRI_AW-1:0] pref_secondary_limit;
    logic [PRI_AW-1:0] pref_base_offset;
    // dma windows ignore remap_en
    logic              remap_en;

    assign remap_en                = ctrl_reg[remap_pkg::CTRL_REMAP_EN];
    assign nonpref_primary_base    = to_base(np_pri_base_reg);
    assign nonpref_primary_limit   = to_limit(np_pri_lim_reg);
    assign pref_primary_base       = to_base(pf_pri_base_reg);
    assign pref_primary_limit      = to_limit(pf_pri_lim_reg);
    // with remap off the secondary windows coincide with the primary ones
    assign nonpref_secondary_base  = remap_en ? to_base(np_sec_base_reg) : nonpref_primary_base;
    assign pref_secondary_base     = remap_en ? to_base(pf_sec_base_reg) : pref_primary_base;

    // all offsets wrap
    assign nonpref_base_offset     = nonpref_primary_base - nonpref_secondary_base;
    assign pref_base_offset        = pref_primary_base - pref_secondary_base;
    assign nonpref_secondary_limit = nonpref_primary_limit - nonpref_base_offset;
    assign pref_secondary_limit    = pref_primary_limit - pref_base_offset;

////////////////////////////////////////////////////////////////////////////////
// dma windows

    // index 0 wins on overlap
    logic [SEC_AW-1:0] upstream_secondary_address;
    logic [PRI_AW-1:0] win_pri_addr [WIN_COUNT];
    logic [PRI_AW-1:0] upstream_window_primary_limit [WIN_COUNT];
    logic [WIN_COUNT-1:0] win_hit;

    assign upstream_secondary_address = i_up.addr;

    // one unit per window
    for (genvar w = 0; w < WIN_COUNT; w++) begin : g_win
        upstream_window #(
            .PRI_AW (PRI_AW),
            .SEC_AW (SEC_AW)
        ) u_win (
            .i_sec_base  (to_base(win_sec_base_reg[w])),
            .i_sec_limit (to_limit(win_sec_lim_reg[w])),
            .i_pri_base  (to_base(win_pri_base_reg[w])),
            .i_addr      (upstream_secondary_address),
            .o_hit       (win_hit[w]),
            .o_pri_addr  (win_pri_addr[w]),
            .o_pri_limit (upstream_window_primary_limit[w])
        );
    end

////////////////////////////////////////////////////////////////////////////////
// register writes

    // fixed map registers
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_reg        <= remap_pkg::CTRL_RESET;
            io_size_reg     <= remap_pkg::IO_SIZE_RESET;
            np_pri_base_reg <= remap_pkg::WIN_RESET;
            np_pri_lim_reg  <= remap_pkg::WIN_RESET;
            np_sec_base_reg <= remap_pkg::WIN_RESET;
            pf_pri_base_reg <= remap_pkg::WIN_RESET;
            pf_pri_lim_reg  <= remap_pkg::WIN_RESET;
            pf_sec_base_reg <= remap_pkg::WIN_RESET;
        end else if (i_reg_write) begin
            case (i_reg_addr)
                remap_pkg::OFS_CTRL:        ctrl_reg        <= i_reg_wdata[2:0];
                remap_pkg::OFS_IO_SIZE:     io_size_reg     <= i_reg_wdata[4:0];
                remap_pkg::OFS_NP_PRI_BASE: np_pri_base_reg <= i_reg_wdata;
                remap_pkg::OFS_NP_PRI_LIM:  np_pri_lim_reg  <= i_reg_wdata;
                remap_pkg::OFS_NP_SEC_BASE: np_sec_base_reg <= i_reg_wdata;
                remap_pkg::OFS_PF_PRI_BASE: pf_pri_base_reg <= i_reg_wdata;
                remap_pkg::OFS_PF_PRI_LIM:  pf_pri_lim_reg  <= i_reg_wdata;
                remap_pkg::OFS_PF_SEC_BASE: pf_sec_base_reg <= i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // dma window registers
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int w = 0; w < WIN_COUNT; w++) begin
                win_sec_base_reg[w] <= remap_pkg::WIN_RESET;
                win_sec_lim_reg[w]  <= remap_pkg::WIN_RESET;
                win_pri_base_reg[w] <= remap_pkg::WIN_RESET;
            end
        end else if (i_reg_write) begin
            for (int w = 0; w < WIN_COUNT; w++) begin
                if (win_sel(i_reg_addr, w, remap_pkg::WIN_SEC_BASE)) begin
                    win_sec_base_reg[w] <= i_reg_wdata;
                end

                if (win_sel(i_reg_addr, w, remap_pkg::WIN_SEC_LIM)) begin
                    win_sec_lim_reg[w] <= i_reg_wdata;
                end

                if (win_sel(i_reg_addr, w, remap_pkg::WIN_PRI_BASE)) begin
                    win_pri_base_reg[w] <= i_reg_wdata;
                end
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// register reads: derived limits and status read back, unmapped reads give zero

    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = remap_pkg::UNMAPPED_READ;

        case (i_reg_addr)
            remap_pkg::OFS_CTRL:        rdata_next = {29'h0000_0000, ctrl_reg};
            remap_pkg::OFS_IO_SIZE:     rdata_next = {27'h000_0000, io_size_reg};
            remap_pkg::OFS_NP_PRI_BASE: rdata_next = np_pri_base_reg;
            remap_pkg::OFS_NP_PRI_LIM:  rdata_next = np_pri_lim_reg;
            remap_pkg::OFS_NP_SEC_BASE: rdata_next = np_sec_base_reg;
            remap_pkg::OFS_PF_PRI_BASE: rdata_next = pf_pri_base_reg;
            remap_pkg::OFS_PF_PRI_LIM:  rdata_next = pf_pri_lim_reg;
            remap_pkg::OFS_PF_SEC_BASE: rdata_next = pf_sec_base_reg;
            remap_pkg::OFS_NP_SEC_LIM:  rdata_next = to_gran(nonpref_secondary_limit);
            remap_pkg::OFS_PF_SEC_LIM:  rdata_next = to_gran(pref_secondary_limit);
            remap_pkg::OFS_STATUS:      rdata_next = {{(32-WIN_COUNT){1'b0}}, win_hit};
            default: begin
            end
        endcase

        // window map overlay
        for (int w = 0; w < WIN_COUNT; w++) begin
            if (win_sel(i_reg_addr, w, remap_pkg::WIN_SEC_BASE)) begin
                rdata_next = win_sec_base_reg[w];
            end

            if (win_sel(i_reg_addr, w, remap_pkg::WIN_SEC_LIM)) begin
                rdata_next = win_sec_lim_reg[w];
            end

            if (win_sel(i_reg_addr, w, remap_pkg::WIN_PRI_BASE)) begin
                rdata_next = win_pri_base_reg[w];
            end

            if (win_sel(i_reg_addr, w, remap_pkg::WIN_PRI_LIM)) begin
                rdata_next = to_gran(upstream_window_primary_limit[w]);
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= remap_pkg::UNMAPPED_READ;
        end else begin
            o_reg_rdata <= i_reg_read ? rdata_next : remap_pkg::UNMAPPED_READ;
        end
    end

    // legacy decode enables make decoding undefined while remapping; flag it to software
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_decode_undefined <= 1'b0;
        end else begin
            o_decode_undefined <= remap_en && (ctrl_reg[remap_pkg::CTRL_VGA_EN]
                                  || ctrl_reg[remap_pkg::CTRL_ISA_EN]);
        end
    end

////////////////////////////////////////////////////////////////////////////////
// downstream path

    logic [PRI_AW-1:0] nonpref_primary_address;
    logic [PRI_AW-1:0] pref_primary_address;
    logic [PRI_AW-1:0] nonpref_secondary_address;
    logic [PRI_AW-1:0] pref_secondary_address;
    logic [IO_AW-1:0]  io_mask;
    logic              np_claim;
    logic              pf_claim;
    remap_pkg::down_rsp_t down_next;

    assign nonpref_primary_address   = i_down.addr;
    assign pref_primary_address      = i_down.addr;
    assign nonpref_secondary_address = nonpref_primary_address - nonpref_base_offset;
    assign pref_secondary_address    = pref_primary_address - pref_base_offset;
    // remapping never changes which cycles are claimed
    assign np_claim = in_range(i_down.addr, nonpref_primary_base, nonpref_primary_limit);
    assign pf_claim = in_range(i_down.addr, pref_primary_base, pref_primary_limit);
    // io size above the port width clears the whole address
    assign io_mask  = (io_size_reg >= 5'(IO_AW)) ? '0 : ({IO_AW{1'b1}} >> io_size_reg);

    always_comb begin
        down_next       = '0;
        down_next.valid = i_down.valid;

        if (i_down.is_io) begin
            down_next.claim = 1'b1;
            down_next.addr  = SEC_AW'(i_down.addr[IO_AW-1:0] & io_mask);
        end else if (i_down.is_pref) begin
            down_next.claim = pf_claim;
            down_next.addr  = pref_secondary_address[SEC_AW-1:0];
        end else begin
            down_next.claim = np_claim;
            down_next.addr  = nonpref_secondary_address[SEC_AW-1:0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_down <= '0;
        end else begin
            o_down <= down_next;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// upstream path; lowest numbered window wins if software lets windows overlap

    logic [PRI_AW-1:0] up_wide;
    logic              in_sec_mem;
    remap_pkg::up_rsp_t up_next;

    // zero-extend to primary width
    assign up_wide    = {{(PRI_AW-SEC_AW){1'b0}}, i_up.addr};
    assign in_sec_mem = in_range(up_wide, nonpref_secondary_base, nonpref_secondary_limit)
                     || in_range(up_wide, pref_secondary_base, pref_secondary_limit);

    always_comb begin
        up_next           = '0;
        up_next.valid     = i_up.valid;
        up_next.claim     = !in_sec_mem;
        up_next.addr      = up_wide;

        for (int w = WIN_COUNT - 1; w >= 0; w--) begin
            // overlap with memory windows is undefined; the window hit takes it
            if (win_hit[w]) begin
                up_next.in_window = 1'b1;
                up_next.claim     = 1'b1;
                up_next.addr      = win_pri_addr[w];
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_up <= '0;
        end else begin
            o_up <= up_next;
        end
    end

endmodule

// *** remap_pkg.sv ***
// package for the bridge address remapper: widths, register offsets, reset values, carriers
// assumes a single core clock domain and a plain strobe register port
package remap_pkg;

    localparam int PRI_AW    = 40;
    localparam int SEC_AW    = 32;
    localparam int IO_AW     = 25;
    localparam int WIN_COUNT = 2;

    // register word offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL         = 8'h00;
    localparam logic [7:0] OFS_IO_SIZE      = 8'h04;
    localparam logic [7:0] OFS_NP_PRI_BASE  = 8'h08;
    localparam logic [7:0] OFS_NP_PRI_LIM   = 8'h0c;
    localparam logic [7:0] OFS_NP_SEC_BASE  = 8'h10;
    localparam logic [7:0] OFS_PF_PRI_BASE  = 8'h14;
    localparam logic [7:0] OFS_PF_PRI_LIM   = 8'h18;
    localparam logic [7:0] OFS_PF_SEC_BASE  = 8'h1c;
    localparam logic [7:0] OFS_NP_SEC_LIM   = 8'h20;
    localparam logic [7:0] OFS_PF_SEC_LIM   = 8'h24;
    localparam logic [7:0] OFS_STATUS       = 8'h28;
    localparam logic [7:0] OFS_WIN0         = 8'h40;
    localparam logic [7:0] WIN_STRIDE       = 8'h10;
    localparam logic [7:0] WIN_SEC_BASE     = 8'h00;
    localparam logic [7:0] WIN_SEC_LIM      = 8'h04;
    localparam logic [7:0] WIN_PRI_BASE     = 8'h08;
    localparam logic [7:0] WIN_PRI_LIM      = 8'h0c;

    // window registers hold address bits [39:8] (256-byte granules)
    localparam int GRAN_SHIFT = 8;

    // control register fields
    localparam int CTRL_REMAP_EN = 0;
    localparam int CTRL_VGA_EN   = 1;
    localparam int CTRL_ISA_EN   = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;
    localparam logic [4:0]  IO_SIZE_RESET = 5'h00;
    localparam logic [31:0] WIN_RESET     = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    typedef struct packed {
        logic              valid;
        logic              is_io;
        logic              is_pref;
        logic [PRI_AW-1:0] addr;
    } down_req_t;

    typedef struct packed {
        logic              valid;
        logic              claim;
        logic [SEC_AW-1:0] addr;
    } down_rsp_t;

    typedef struct packed {
        logic              valid;
        logic [SEC_AW-1:0] addr;
    } up_req_t;

    typedef struct packed {
        logic              valid;
        logic              claim;
        logic              in_window;
        logic [PRI_AW-1:0] addr;
    } up_rsp_t;

endpackage

// *** upstream_window.sv ***
// one upstream relocation window: hit test and relocated address
// assumes limit registers are inclusive granule numbers
`timescale 1ns/1ns
module upstream_window #(
    parameter int PRI_AW = 40,
    parameter int SEC_AW = 32
) (
    // window programming
    input  wire logic [PRI_AW-1:0] i_sec_base,
    input  wire logic [PRI_AW-1:0] i_sec_limit,
    input  wire logic [PRI_AW-1:0] i_pri_base,
    // address under test
    input  wire logic [SEC_AW-1:0] i_addr,
    // results
    output logic                   o_hit,
    output logic [PRI_AW-1:0]      o_pri_addr,
    output logic [PRI_AW-1:0]      o_pri_limit
);
    logic [PRI_AW-1:0] upstream_window_offset;
    logic [PRI_AW-1:0] addr_wide;

    // modular arithmetic: offsets wrap, nothing saturates
    assign upstream_window_offset = i_pri_base - i_sec_base;
    assign addr_wide   = {{(PRI_AW-SEC_AW){1'b0}}, i_addr};
    assign o_pri_limit = i_sec_limit + upstream_window_offset;
    assign o_hit       = (addr_wide >= i_sec_base) && (addr_wide <= i_sec_limit);
    assign o_pri_addr  = addr_wide + upstream_window_offset;
endmodule

// *** remap_monitor.sv ***
// checker for the bridge address remapper, bound to its top module
// assumes one-cycle registered answers and write effects one cycle later
`timescale 1ns/1ns
module remap_monitor #(
    parameter int IO_AW = remap_pkg::IO_AW
) (
    input wire logic                 i_ref_clk,
    input wire logic                 i_reset,
    input wire logic [7:0]           i_reg_addr,
    input wire logic [31:0]          i_reg_wdata,
    input wire logic                 i_reg_write,
    input wire logic                 i_reg_read,
    input wire logic [31:0]          o_reg_rdata,
    input wire remap_pkg::down_req_t i_down,
    input wire remap_pkg::down_rsp_t o_down,
    input wire remap_pkg::up_req_t   i_up,
    input wire remap_pkg::up_rsp_t   o_up,
    input wire logic                 o_decode_undefined
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);
    logic             armed;
    logic [4:0]       io_size_sh;
    logic [2:0]       ctrl_sh;
    logic [IO_AW-1:0] io_mask;
    // shadows of the control words; the datapath sees a write one cycle later, as here
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            armed <= 1'b0;
            io_size_sh <= 5'h00;
            ctrl_sh <= 3'h0;
        end else begin
            armed <= 1'b1;
            if (i_reg_write && i_reg_addr == remap_pkg::OFS_IO_SIZE) io_size_sh <= i_reg_wdata[4:0];
            if (i_reg_write && i_reg_addr == remap_pkg::OFS_CTRL) ctrl_sh <= i_reg_wdata[2:0];
        end
    end
    always_comb io_mask = (io_size_sh >= 5'(IO_AW)) ? '0 : ({IO_AW{1'b1}} >> io_size_sh);
    property p_down_valid;
        armed |-> o_down.valid == $past(i_down.valid);
    endproperty
    a_down_valid: assert property (p_down_valid) else $error("downstream answer latency wrong");
    property p_io_claim;
        $past(i_down.valid && i_down.is_io) |-> o_down.valid && o_down.claim;
    endproperty
    a_io_claim: assert property (p_io_claim) else $error("i/o cycle not claimed");
    property p_io_alias;
        $past(i_down.valid && i_down.is_io)
            |-> o_down.addr[IO_AW-1:0] == ($past(i_down.addr[IO_AW-1:0]) & $past(io_mask));
    endproperty
    a_io_alias: assert property (p_io_alias) else $error("i/o alias bits wrong");
    property p_io_upper_zero;
        $past(i_down.valid && i_down.is_io) |-> o_down.addr[remap_pkg::SEC_AW-1:IO_AW] == '0;
    endproperty
    a_io_upper_zero: assert property (p_io_upper_zero) else $error("i/o upper bits set");
    property p_rdata_idle;
        !$past(i_reg_read) |-> o_reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
    property p_up_valid;
        armed |-> o_up.valid == $past(i_up.valid);
    endproperty
    a_up_valid: assert property (p_up_valid) else $error("upstream answer latency wrong");
    property p_up_pass;
        o_up.valid && o_up.claim && !o_up.in_window |-> o_up.addr == 40'($past(i_up.addr));
    endproperty
    a_up_pass: assert property (p_up_pass) else $error("upstream miss address changed");
    property p_window_claim;
        o_up.valid && o_up.in_window |-> o_up.claim;
    endproperty
    a_window_claim: assert property (p_window_claim) else $error("window hit not claimed");
    property p_decode;
        armed |-> o_decode_undefined == $past(ctrl_sh[0] && (ctrl_sh[1] || ctrl_sh[2]));
    endproperty
    a_decode: assert property (p_decode) else $error("decode state flag wrong");
endmodule
bind bridge_address_remapper remap_monitor #(.IO_AW(IO_AW)) remap_monitor_inst (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata), .i_down(i_down), .o_down(o_down), .i_up(i_up), .o_up(o_up),
    .o_decode_undefined(o_decode_undefined));

// *** secondary_agent_model.sv ***
// secondary bus agent: presents one upstream address for each request pulse
// assumes the bench raises i_go for one cycle at a time
`timescale 1ns/1ns
module secondary_agent_model (
    input  wire logic          i_ref_clk,
    input  wire logic          i_reset,
    input  wire logic          i_go,
    input  wire logic [31:0]   i_addr,
    output remap_pkg::up_req_t o_up
);
    // a released bus inverts its address every cycle, so the last address comes back on alternate cycles
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) o_up <= '0;
        else o_up <= '{valid: i_go, addr: i_go ? i_addr : ~o_up.addr};
    end
endmodule

// *** bridge_address_remapper_bench.sv ***
// self-checking bench for the bridge address remapper
// assumes one-cycle answers on the register port and both datapaths
`timescale 1ns/1ns
module bridge_address_remapper_bench;
    logic [7:0]           i_reg_addr;
    logic [31:0]          i_reg_wdata, o_reg_rdata, agent_addr;
    logic                 i_ref_clk, i_reset, i_reg_write, i_reg_read, o_decode_undefined;
    logic                 agent_go;
    remap_pkg::down_req_t i_down;
    remap_pkg::down_rsp_t o_down;
    remap_pkg::up_req_t   i_up;
    remap_pkg::up_rsp_t   o_up;
    int                   num_errors, checks, cycles;
    int                   io_sizes[5] = '{0, 6, 24, 25, 31};
    // memory windows kept clear of dma windows; legacy decodes off while remapping
    logic [7:0]  cfg_ofs[13] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                                 8'h40, 8'h44, 8'h48, 8'h50, 8'h54, 8'h58};
    logic [31:0] cfg_val[13] = '{32'h1, 32'h0880_0000, 32'h08bf_ffff, 32'h0, 32'h09c0_0000,
                                 32'h09ff_ffff, 32'h00c0_0000, 32'h0040_0000, 32'h005f_ffff,
                                 32'h0100_0000, 32'h0060_0000, 32'h006f_ffff, 32'h0};

    bridge_address_remapper bridge_address_remapper_inst (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
        .i_down(i_down), .o_down(o_down), .i_up(i_up), .o_up(o_up),
        .o_decode_undefined(o_decode_undefined));
    secondary_agent_model secondary_agent_model_inst (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .i_go(agent_go), .i_addr(agent_addr), .o_up(i_up));

    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_read <= 1'b0;
        #1 chk("rdata", e, o_reg_rdata);
    endtask
    task automatic dn(input logic io, pf, input logic [39:0] a, input logic cl,
                      input logic [39:0] e);
        @(posedge i_ref_clk);
        i_down <= '{valid: 1'b1, is_io: io, is_pref: pf, addr: a};
        @(posedge i_ref_clk);
        i_down <= '0;
        #1 chk("down claim", cl, o_down.claim);
        if (cl) chk("down addr", e, o_down.addr);
    endtask
    task automatic up(input logic [31:0] s, input logic cl, w, input logic [39:0] e);
        @(posedge i_ref_clk);
        agent_go <= 1'b1;
        agent_addr <= s;
        @(posedge i_ref_clk);
        agent_go <= 1'b0;
        @(posedge i_ref_clk);
        #1 chk("up claim", cl, o_up.claim);
        chk("up window", w, o_up.in_window);
        if (cl) chk("up addr", e, o_up.addr);
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // generous ceiling; the sequence needs well under a thousand cycles
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_reset = 1'b1;
        {i_reg_addr, i_reg_wdata, i_reg_write, i_reg_read, agent_go, agent_addr} = '0;
        i_down = '0;
        repeat (12) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        for (int a = 0; a < 40; a += 4) rd(8'(a), 32'h0);
        rd(8'h3c, 32'h0);
        wr(remap_pkg::OFS_IO_SIZE, 32'hffff_ffff);
        rd(remap_pkg::OFS_IO_SIZE, 32'h0000_001f);
        foreach (io_sizes[i]) begin
            wr(remap_pkg::OFS_IO_SIZE, 32'(io_sizes[i]));
            dn(1'b1, 1'b0, 40'hff_ffff_ffff, 1'b1, (io_sizes[i] >= remap_pkg::IO_AW) ? 40'h0 :
               40'(25'h1ff_ffff >> io_sizes[i]));
        end
        foreach (cfg_ofs[i]) wr(cfg_ofs[i], cfg_val[i]);
        wr(remap_pkg::OFS_NP_SEC_LIM, 32'h1234_5678);
        rd(remap_pkg::OFS_NP_SEC_LIM, 32'h003f_ffff);
        rd(remap_pkg::OFS_PF_SEC_LIM, 32'h00ff_ffff);
        rd(8'h4c, 32'h011f_ffff);
        rd(8'h5c, 32'h000f_ffff);
        dn(1'b0, 1'b0, 40'h08_8000_1234, 1'b1, 40'h0000_1234);
        dn(1'b0, 1'b0, 40'h08_bfff_ffff, 1'b1, 40'h3fff_ffff);
        dn(1'b0, 1'b0, 40'h08_c000_0000, 1'b0, 40'h0);
        dn(1'b0, 1'b0, 40'h08_7fff_ffff, 1'b0, 40'h0);
        dn(1'b0, 1'b1, 40'h09_c000_0004, 1'b1, 40'hc000_0004);
        dn(1'b0, 1'b1, 40'h09_ffff_ffff, 1'b1, 40'hffff_ffff);
        dn(1'b0, 1'b1, 40'h0a_0000_0000, 1'b0, 40'h0);
        up(32'h4000_0010, 1'b1, 1'b1, 40'h01_0000_0010);
        up(32'h5fff_ffff, 1'b1, 1'b1, 40'h01_1fff_ffff);
        up(32'h6000_0100, 1'b1, 1'b1, 40'h00_0000_0100);
        up(32'h7000_0000, 1'b1, 1'b0, 40'h00_7000_0000);
        up(32'hbfff_ffff, 1'b1, 1'b0, 40'h00_bfff_ffff);
        up(32'h3fff_ffff, 1'b0, 1'b0, 40'h0);
        up(32'hc000_0000, 1'b0, 1'b0, 40'h0);
        for (int v = 0; v < 8; v++) begin
            wr(remap_pkg::OFS_CTRL, 32'(v));
            @(posedge i_ref_clk);
            #1 chk("decode", 40'(v[0] & (v[1] | v[2])), o_decode_undefined);
        end
        wr(remap_pkg::OFS_CTRL, 32'h0);
        dn(1'b0, 1'b0, 40'h08_8000_1234, 1'b1, 40'h8000_1234);
        conclude();
    end
endmodule
